// >>> src/acl_map.svh
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ACL_IDX_BASE        12'h600
`define ACL_IDX_MAC_3124    12'h604
`define ACL_IDX_MAC_2316    12'h605
`define ACL_IDX_MAC_158     12'h606
`define ACL_IDX_MAC_70      12'h607
`define ACL_IDX_ETYPE_HIGH  12'h608
`define ACL_IDX_ETYPE_LOW   12'h609
`define ACL_IDX_PRIO_CTRL   12'h60a
`define ACL_IDX_RMK_MAP     12'h60b
`define ACL_IDX_SPARE       12'h60c
`define ACL_IDX_FWD_MAP     12'h60d
`define ACL_IDX_RULE_HIGH   12'h60e
`define ACL_IDX_RULE_LOW    12'h60f
`define ACL_IDX_SEL_HIGH    12'h610
`define ACL_IDX_SEL_LOW     12'h611
`define ACL_IDX_ACCESS_CTRL 12'h612

// ****************************************************************
// Staging bytes held here and entry geometry
// ****************************************************************
`define ACL_FIRST_BYTE      4
`define ACL_LAST_BYTE       15
`define ACL_ENTRIES         16
`define ACL_INDEX_W         4

// ****************************************************************
// Field positions
// ****************************************************************
`define ACL_PRIO_KIND_MSB   7
`define ACL_PRIO_KIND_LSB   6
`define ACL_PRIO_MSB        5
`define ACL_PRIO_LSB        3
`define ACL_RMK_EN_BIT      2
`define ACL_RMK_HI_MSB      1
`define ACL_RMK_HI_LSB      0
`define ACL_RMK_LO_BIT      7
`define ACL_MAP_KIND_MSB    6
`define ACL_MAP_KIND_LSB    5
`define ACL_FWD_P1_BIT      0
`define ACL_FWD_P4_BIT      3
`define ACL_FWD_P5_BIT      6
`define ACL_CTL_WR_DONE_BIT 6
`define ACL_CTL_RD_DONE_BIT 5
`define ACL_CTL_WRITE_BIT   4
`define ACL_CTL_INDEX_MSB   3

// ****************************************************************
// Reset values
// ****************************************************************
`define ACL_RST_BYTE        8'h00
`define ACL_RST_DONE        1'b1

`endif

// >>> src/acl_pkg.sv
package acl_pkg;

   typedef enum logic {
      ACL_IDLE,
      ACL_BUSY
   } acl_xfer_state_type;

   typedef logic [7:0] acl_byte_type;

endpackage : acl_pkg

// >>> src/acl_tbl_if.sv
`timescale 1ns/1ps
`include "acl_map.svh"

interface acl_tbl_if;
   logic                        start;
   logic                        wr;
   logic [`ACL_INDEX_W-1:0]     idx;
   logic [`ACL_LAST_BYTE:`ACL_FIRST_BYTE] en;
   logic [95:0]                 wdata;
   logic [95:0]                 rdata;
   logic                        done;

   modport ctl (output start, output wr, output idx, output en, output wdata,
                input rdata, input done);
   modport mem (input start, input wr, input idx, input en, input wdata,
                output rdata, output done);
endinterface : acl_tbl_if

// >>> src/acl_entry_table.sv
`timescale 1ns/1ps
`include "acl_map.svh"

module acl_entry_table #(
   parameter int ENTRIES = `ACL_ENTRIES
) (
   input  wire logic clk,
   input  wire logic resetn,
   acl_tbl_if.mem    tb
);

   logic [95:0] mem [ENTRIES];

   // ****************************************************************
   // Entry storage: one access per start, answer on the next cycle
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int e = 0; e < ENTRIES; e++) begin
            mem[e] <= 96'h0;
         end
      end else if (tb.start && tb.wr) begin
         // Only selected bytes of the entry are replaced
         for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
            if (tb.en[k]) begin
               mem[tb.idx][(k-`ACL_FIRST_BYTE)*8 +: 8] <= tb.wdata[(k-`ACL_FIRST_BYTE)*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tb.rdata <= 96'h0;
      end else if (tb.start && !tb.wr) begin
         tb.rdata <= mem[tb.idx];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tb.done <= 1'b0;
      end else begin
         tb.done <= tb.start;
      end
   end

endmodule : acl_entry_table

// >>> src/acl_entry_access_window.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "acl_map.svh"

// What this block does
// - Remark priority bits 2:1 sit in bits 1:0 of the priority byte.
// - Remark priority bit 0 sits in bit 7 next to map kind bits 6:5.
// - Priority byte holds select kind 7:6, priority 5:3, remark enable bit 2.
// - Forward map byte: ports 1-4 in bits 0-3, port 5 in bit 6.
// - Only bytes whose select bit is one move between table and staging.
// - Writing the low select register starts the transfer; write high first.
// - High select register bit 0 picks byte 7, bit 3 picks byte 4; bits 7:4 pick no byte.
// - Low select register bit 0 picks byte 15, bit 7 picks byte 8.
// - Read-complete flag drops during a read, rises when it ends.
// - Write-complete flag reads zero while a write pends, one after.
module acl_entry_access_window #(
   parameter int ENTRIES = `ACL_ENTRIES
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);

   if (ENTRIES < 1 || ENTRIES > (1 << `ACL_INDEX_W)) begin : g_bad_entries
      $error("ENTRIES must lie between 1 and the reach of the entry index");
   end

   acl_tbl_if tb ();

   acl_entry_table #(
      .ENTRIES (ENTRIES)
   ) u_table (
      .clk    (clk),
      .resetn (resetn),
      .tb     (tb.mem)
   );

   // ****************************************************************
   // AHB-Lite slave front end
   // ****************************************************************
   logic                        ap_take;
   logic                        wr_pend;
   logic                        rd_pend;
   logic [11:0]                 ap_word;
   logic                        ap_ok;
   logic                        wr_fire;
   acl_pkg::acl_byte_type       wbyte;
   acl_pkg::acl_byte_type       rd_mux;

   assign ap_take = hsel && htrans[1] && hready;
   assign wr_fire = wr_pend && ap_ok;
   assign wbyte   = hwdata[7:0];

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ap_word <= 12'h000;
         ap_ok   <= 1'b0;
      end else begin
         wr_pend <= ap_take && hwrite;
         rd_pend <= ap_take && !hwrite;
         if (ap_take) begin
            ap_word <= haddr[13:2];
            // Anything outside the window reads zero and ignores writes
            ap_ok   <= (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'b00);
         end
      end
   end

   // Reads take one wait state so a write just before is always seen
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hreadyout <= 1'b1;
      end else if (ap_take && !hwrite) begin
         hreadyout <= 1'b0;
      end else if (rd_pend) begin
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_pend) begin
         hrdata <= {24'h000000, ap_ok ? rd_mux : 8'h00};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // ****************************************************************
   // Staging bytes, select registers, access control
   // ****************************************************************
   acl_pkg::acl_byte_type              stage [`ACL_FIRST_BYTE:`ACL_LAST_BYTE];
   acl_pkg::acl_byte_type              sel_high;
   acl_pkg::acl_byte_type              sel_low;
   logic                               xfer_wr;
   logic [`ACL_INDEX_W-1:0]            xfer_idx;
   logic                               rd_done;
   logic                               wr_done;
   logic                               trig;
   logic                               read_back;
   acl_pkg::acl_xfer_state_type        state;
   logic [15:0]                        sel_word;

   assign trig      = wr_fire && (ap_word == `ACL_IDX_SEL_LOW) && (state == acl_pkg::ACL_IDLE);
   assign read_back = tb.done && !tb.wr;
   assign sel_word  = {sel_high, wbyte};

   for (genvar k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin : g_byte
      always_ff @(posedge clk) begin
         if (!resetn) begin
            stage[k] <= `ACL_RST_BYTE;
         end else if (read_back && tb.en[k]) begin
            stage[k] <= tb.rdata[(k-`ACL_FIRST_BYTE)*8 +: 8];
         end else if (wr_fire && ap_word == 12'(`ACL_IDX_BASE + k)) begin
            // All eight bits stored, reserved ones too
            stage[k] <= wbyte;
         end
      end

      // Select bits are numbered against the byte order
      always_ff @(posedge clk) begin
         if (!resetn) begin
            tb.en[k] <= 1'b0;
         end else if (trig) begin
            tb.en[k] <= sel_word[15-k];
         end
      end

      always_ff @(posedge clk) begin
         if (!resetn) begin
            tb.wdata[(k-`ACL_FIRST_BYTE)*8 +: 8] <= `ACL_RST_BYTE;
         end else if (trig) begin
            tb.wdata[(k-`ACL_FIRST_BYTE)*8 +: 8] <= stage[k];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sel_high <= `ACL_RST_BYTE;
      end else if (wr_fire && ap_word == `ACL_IDX_SEL_HIGH) begin
         sel_high <= wbyte;
      end
   end

   // Stored even when busy; a trigger while busy starts nothing
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sel_low <= `ACL_RST_BYTE;
      end else if (wr_fire && ap_word == `ACL_IDX_SEL_LOW) begin
         sel_low <= wbyte;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         xfer_wr  <= 1'b0;
         xfer_idx <= '0;
      end else if (wr_fire && ap_word == `ACL_IDX_ACCESS_CTRL) begin
         xfer_wr  <= wbyte[`ACL_CTL_WRITE_BIT];
         xfer_idx <= wbyte[`ACL_CTL_INDEX_MSB:0];
      end
   end

   // ****************************************************************
   // Transfer sequencing
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= acl_pkg::ACL_IDLE;
      end else begin
         case (state)
            acl_pkg::ACL_IDLE: begin
               if (trig) begin
                  state <= acl_pkg::ACL_BUSY;
               end
            end
            acl_pkg::ACL_BUSY: begin
               if (tb.done) begin
                  state <= acl_pkg::ACL_IDLE;
               end
            end
            default: begin
               state <= acl_pkg::ACL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tb.start <= 1'b0;
         tb.wr    <= 1'b0;
         tb.idx   <= '0;
      end else begin
         tb.start <= trig;
         if (trig) begin
            tb.wr  <= xfer_wr;
            // Indices past the table wrap rather than miss
            tb.idx <= (ENTRIES == (1 << `ACL_INDEX_W)) ? xfer_idx
                      : `ACL_INDEX_W'(32'(xfer_idx) % ENTRIES);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_done <= `ACL_RST_DONE;
      end else if (trig && !xfer_wr) begin
         rd_done <= 1'b0;
      end else if (read_back) begin
         rd_done <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_done <= `ACL_RST_DONE;
      end else if (trig && xfer_wr) begin
         wr_done <= 1'b0;
      end else if (tb.done && tb.wr) begin
         wr_done <= 1'b1;
      end
   end

   // ****************************************************************
   // Read mux
   // ****************************************************************
   always_comb begin
      rd_mux = 8'h00;
      for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
         if (ap_word == 12'(`ACL_IDX_BASE + k)) begin
            rd_mux = stage[k];
         end
      end
      if (ap_word == `ACL_IDX_SEL_HIGH) begin
         rd_mux = sel_high;
      end
      if (ap_word == `ACL_IDX_SEL_LOW) begin
         rd_mux = sel_low;
      end
      if (ap_word == `ACL_IDX_ACCESS_CTRL) begin
         rd_mux = {1'b0, wr_done, rd_done, xfer_wr, xfer_idx};
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic bus_a;
   logic bus_b;
   logic bus_c;
   logic bus_d;
   assign bus_a = wr_fire && ap_word == `ACL_IDX_PRIO_CTRL && !(read_back && tb.en[10]);
   assign bus_b = wr_fire && ap_word == `ACL_IDX_RMK_MAP && !(read_back && tb.en[11]);
   assign bus_c = wr_fire && ap_word == `ACL_IDX_SPARE && !(read_back && tb.en[12]);
   assign bus_d = wr_fire && ap_word == `ACL_IDX_FWD_MAP && !(read_back && tb.en[13]);

   property p_remark_high;
      bus_a |=> stage[10][`ACL_RMK_HI_MSB:`ACL_RMK_HI_LSB] == ($past(wbyte) & 8'h03);
   endproperty
   a_remark_high: assert property (p_remark_high) else $error("remark high bits not stored");
   property p_remark_low_map;
      bus_b |=> stage[11][`ACL_RMK_LO_BIT] == $past(wbyte[7])
                && stage[11][`ACL_MAP_KIND_MSB:`ACL_MAP_KIND_LSB] == $past(wbyte[6:5]);
   endproperty
   a_remark_low_map: assert property (p_remark_low_map) else $error("remark low or map kind wrong");
   property p_prio_fields;
      bus_a |=> (stage[10] & 8'hfc) == ($past(wbyte) & 8'hfc);
   endproperty
   a_prio_fields: assert property (p_prio_fields) else $error("priority fields not stored");
   property p_forward_map;
      bus_d |=> stage[13][`ACL_FWD_P5_BIT] == $past(wbyte[6])
                && stage[13][`ACL_FWD_P4_BIT:`ACL_FWD_P1_BIT] == $past(wbyte[3:0]);
   endproperty
   a_forward_map: assert property (p_forward_map) else $error("forward map bits wrong");
   // Byte 4 is the one a partial read most often leaves out
   property p_masked_read;
      read_back && !tb.en[4] && !(wr_fire && ap_word == `ACL_IDX_MAC_3124)
         |=> stage[4] == $past(stage[4]);
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("unselected byte changed");
   sequence s_trigger;
      trig;
   endsequence
   sequence s_table_cycle;
      tb.start ##1 tb.done;
   endsequence
   property p_trigger_starts;
      s_trigger |=> s_table_cycle;
   endproperty
   a_trigger_starts: assert property (p_trigger_starts) else $error("trigger did not start table");
   property p_high_select_order;
      (s_trigger and (sel_high[0] && !sel_high[3])) |=> tb.en[7] && !tb.en[4];
   endproperty
   a_high_select_order: assert property (p_high_select_order) else $error("high select order wrong");
   property p_low_select_order;
      (s_trigger and (wbyte[0] && !wbyte[7])) |=> tb.en[15] && !tb.en[8];
   endproperty
   a_low_select_order: assert property (p_low_select_order) else $error("low select order wrong");
   property p_read_flag;
      (s_trigger and !xfer_wr) |=> !rd_done ##1 !rd_done ##1 rd_done;
   endproperty
   a_read_flag: assert property (p_read_flag) else $error("read flag sequence wrong");
   property p_write_flag;
      (s_trigger and xfer_wr) |=> !wr_done [*2] ##1 wr_done;
   endproperty
   a_write_flag: assert property (p_write_flag) else $error("write flag sequence wrong");
   property p_spare_store;
      bus_c |=> stage[12] == $past(wbyte);
   endproperty
   a_spare_store: assert property (p_spare_store) else $error("spare byte not stored");

endmodule : acl_entry_access_window

// >>> sim/acl_entry_access_window_tb_top.sv
`timescale 1ns/1ps
`include "acl_map.svh"

module acl_entry_access_window_tb_top;

   // ****************************************************************
   // Clock, reset and bus wires
   // ****************************************************************
   logic        clk;
   logic        resetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   int          num_errors;
   int          comparisons;
   logic [31:0] rd;
   logic [7:0]  stage_val [`ACL_FIRST_BYTE:`ACL_LAST_BYTE];

   // One slave on the bus, so its ready is the bus ready
   assign hready = hreadyout;

   acl_entry_access_window #(
      .ENTRIES (`ACL_ENTRIES)
   ) dut (
      .clk       (clk),
      .resetn    (resetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ****************************************************************
   // Reporting
   // ****************************************************************
   task print_verdict;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task check_data(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_data

   // ****************************************************************
   // Bus master
   // ****************************************************************
   // Bounded wait so a stuck slave cannot hang the run
   task wait_ready;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) begin
         num_errors++;
         $display("MISMATCH at %0t: ready %h expected %h", $time, hreadyout, 1'b1);
      end
   endtask : wait_ready

   task bus_xfer(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {18'h0, idx, 2'b00};
      hwrite <= wr;
      hsize  <= 3'b010;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      wait_ready();
      rd = hrdata;
   endtask : bus_xfer

   task reg_write(input logic [11:0] idx, input logic [7:0] val);
      bus_xfer(1'b1, idx, val);
   endtask : reg_write

   task reg_read_check(input logic [11:0] idx, input logic [7:0] exp);
      bus_xfer(1'b0, idx, 8'h00);
      check_data(rd, {24'h0, exp});
   endtask : reg_read_check

   // ****************************************************************
   // Indirect transfer helpers
   // ****************************************************************
   task fill_stage(input logic use_arr, input logic [7:0] v);
      for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
         reg_write(`ACL_IDX_BASE + 12'(k), use_arr ? stage_val[k] : v);
      end
   endtask : fill_stage

   // First status read lands while the transfer is pending, then polls
   task run_xfer(input logic [7:0] ctl, input logic [7:0] hi, input logic [7:0] lo);
      logic [7:0] pend;
      logic [7:0] done;
      int         n;
      pend = {1'b0, ~ctl[4], ctl[4], ctl[4:0]};
      done = {3'b011, ctl[4:0]};
      reg_write(`ACL_IDX_ACCESS_CTRL, ctl);
      reg_write(`ACL_IDX_SEL_HIGH, hi);
      reg_write(`ACL_IDX_SEL_LOW, lo);
      bus_xfer(1'b0, `ACL_IDX_ACCESS_CTRL, 8'h00);
      check_data(rd, {24'h0, pend});
      n = 0;
      while (rd[7:0] !== done && n < 20) begin
         bus_xfer(1'b0, `ACL_IDX_ACCESS_CTRL, 8'h00);
         n++;
      end
      check_data(rd, {24'h0, done});
   endtask : run_xfer

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task test_reset;
      for (int k = `ACL_IDX_MAC_3124; k <= `ACL_IDX_SEL_LOW; k++) begin
         reg_read_check(12'(k), `ACL_RST_BYTE);
      end
      reg_read_check(`ACL_IDX_ACCESS_CTRL, {1'b0, `ACL_RST_DONE, `ACL_RST_DONE, 5'h00});
      reg_read_check(12'h613, 8'h00);
      check_data({31'h0, hresp}, 32'h0);
      $display("test_reset done");
   endtask : test_reset

   task test_fields;
      for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
         stage_val[k] = {k[3:0], ~k[3:0]};
      end
      stage_val[10] = {2'b10, 3'b101, 1'b1, 2'b01};
      stage_val[11] = {1'b1, 2'b11, 5'b10101};
      stage_val[13] = {1'b1, 1'b1, 2'b10, 4'b1011};
      fill_stage(1'b1, 8'h00);
      for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
         reg_read_check(`ACL_IDX_BASE + 12'(k), stage_val[k]);
      end
      reg_write(`ACL_IDX_SEL_HIGH, 8'h5a);
      reg_read_check(`ACL_IDX_SEL_HIGH, 8'h5a);
      // Unmapped writes must not land anywhere
      reg_write(12'h613, 8'hff);
      reg_read_check(12'h613, 8'h00);
      $display("test_fields done");
   endtask : test_fields

   task test_write_read;
      run_xfer(8'h15, 8'hff, 8'hff);
      fill_stage(1'b0, 8'h00);
      run_xfer(8'h05, 8'h05, 8'h81);
      reg_read_check(`ACL_IDX_SEL_LOW, 8'h81);
      for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
         reg_read_check(`ACL_IDX_BASE + 12'(k),
                        (k == 5 || k == 7 || k == 8 || k == 15) ? stage_val[k] : 8'h00);
      end
      $display("test_write_read done");
   endtask : test_write_read

   task test_partial_write;
      fill_stage(1'b0, 8'hee);
      run_xfer(8'h15, 8'h00, 8'h20);
      fill_stage(1'b0, 8'h00);
      run_xfer(8'h05, 8'hff, 8'hff);
      for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
         reg_read_check(`ACL_IDX_BASE + 12'(k), (k == 10) ? 8'hee : stage_val[k]);
      end
      // Another entry was never written; byte 8 is left out and keeps its staged value
      run_xfer(8'h06, 8'hff, 8'h7f);
      for (int k = `ACL_FIRST_BYTE; k <= `ACL_LAST_BYTE; k++) begin
         reg_read_check(`ACL_IDX_BASE + 12'(k), (k == 8) ? stage_val[8] : 8'h00);
      end
      $display("test_partial_write done");
   endtask : test_partial_write

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      num_errors  = 0;
      comparisons = 0;
      resetn      = 1'b0;
      hsel        = 1'b0;
      haddr       = 32'h0;
      htrans      = 2'b00;
      hwrite      = 1'b0;
      hsize       = 3'b010;
      hwdata      = 32'h0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      test_reset();
      test_fields();
      test_write_read();
      test_partial_write();
      print_verdict();
   end

   // Whole run needs a few hundred cycles; allow ample margin
   initial begin
      #200000;
      num_errors++;
      $display("MISMATCH at %0t: timeout %h expected %h", $time, 1'b1, 1'b0);
      print_verdict();
   end

endmodule : acl_entry_access_window_tb_top
